/* rtl/config_nvm_map.vh */
// Constants for the configuration memory controller: cell map, field
// positions, fault values and documented time limits.
// Assumes a 100 MHz system clock.
`ifndef CONFIG_NVM_MAP_VH
`define CONFIG_NVM_MAP_VH

`define CLK_MHZ             100
`define T_READ_INIT_US      50.0
`define T_WRT_ADDR_LOCK_MS  38.0
`define T_WRT_ADDR_OPEN_MS  12.5
`define T_WRT_ID1_USER_MS   38.0
`define T_WRT_ID1_MFR_MS    25.0
`define T_WRT_CELL_MS       12.5

`define CELL_SLAVE_ADDR     4'h0
`define CELL_ID1_USER       4'h1
`define CELL_ID1_MFR        4'h2
`define CELL_PROFILE        4'h4
`define CELL_ID2            4'h5
`define CELL_IO             4'h6
`define CELL_CTRL           4'h7
`define CELL_CTRL2          4'h8
`define CELL_LAST           4'h8
`define MARKER_ADDR         4'hF

`define LOCK_BIT            4
`define DELAY_MODE_BIT      3
`define INVERT_IN_BIT       2
`define BR_BLOCK_BIT        1
`define WD_INHIBIT_BIT      0
`define WD_PIN_SEL_BIT      0
`define DELAY_PIN_SEL_BIT   4
`define ID1_INHIBIT_BIT     4

`define MARKER_ON           5'h01
`define MARKER_OFF          5'h00
`define ADDR_CORRUPT        5'h00
`define CODE_CORRUPT        4'hF

`endif

/* rtl/config_nvm_write_check.v */
// Configuration memory controller: power-on read-out with parity check,
// guarded user-area write with integrity marker, status bits, flag decode.
// Assumes a memory macro on the same clock answering each request with a
// one-cycle mem_done; call strobes come from same-clock protocol logic.
`timescale 1ns/1ps
`include "config_nvm_map.vh"

module config_nvm_write_check #(
  parameter integer INIT_CYC      = `T_READ_INIT_US * `CLK_MHZ,
  parameter integer ADDR_LOCK_CYC = `T_WRT_ADDR_LOCK_MS * 1000 * `CLK_MHZ,
  parameter integer ADDR_OPEN_CYC = `T_WRT_ADDR_OPEN_MS * 1000 * `CLK_MHZ,
  parameter integer ID1_USER_CYC  = `T_WRT_ID1_USER_MS * 1000 * `CLK_MHZ,
  parameter integer ID1_MFR_CYC   = `T_WRT_ID1_MFR_MS * 1000 * `CLK_MHZ,
  parameter integer CELL_CYC      = `T_WRT_CELL_MS * 1000 * `CLK_MHZ
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       addr_assign_call,
  input  wire [4:0] new_address,
  input  wire       write_ext_id_one_call,
  input  wire [3:0] new_ext_id_one,
  input  wire       read_status_call,
  input  wire       broadcast_reset_call,
  input  wire       safety_mode,
  input  wire       peripheral_fault_input,
  input  wire       parameter_pin_zero,
  input  wire       parameter_pin_one,
  input  wire [3:0] data_port_in,
  output wire       mem_req,
  output reg        mem_we,
  output reg  [3:0] mem_addr,
  output reg  [5:0] mem_wdata,
  input  wire       mem_done,
  input  wire [5:0] mem_rdata,
  input  wire [5:0] safe_rdata,
  output reg        init_done,
  output reg  [3:0] status_resp,
  output reg        status_valid,
  output reg        broadcast_reset_exec,
  output reg  [4:0] slave_address,
  output reg  [3:0] profile_code,
  output reg  [3:0] extension_id_one,
  output reg  [3:0] extension_id_two,
  output reg  [3:0] io_code,
  output reg  [3:0] data_port_used,
  output reg        watchdog_enable,
  output reg        delay_active
);

  // Power-on read-out, idle, then one state per memory operation of the guarded write
  localparam [7:0] ST_INIT   = 8'h01;
  localparam [7:0] ST_IDLE   = 8'h02;
  localparam [7:0] ST_MSET_W = 8'h04;
  localparam [7:0] ST_MSET_R = 8'h08;
  localparam [7:0] ST_DATA_W = 8'h10;
  localparam [7:0] ST_DATA_R = 8'h20;
  localparam [7:0] ST_MCLR_W = 8'h40;
  localparam [7:0] ST_MCLR_R = 8'h80;

  // Data bits plus odd parity in the sixth bit
  function [5:0] enc;
    input [4:0] d;
    begin
      enc = {~^d, d};
    end
  endfunction

  reg  [7:0]  state_r;
  reg         go_r;
  reg  [21:0] tmo_r;
  reg  [21:0] step_r;
  reg  [21:0] lim_r;
  reg  [3:0]  idx_r;
  reg  [3:0]  wr_addr_r;
  reg  [4:0]  wr_data_r;
  reg  [5:0]  cell_r [0:8];
  reg         marker_r;
  reg         user_bad_r;
  reg         safe_perr_r;
  reg  [6:0]  pin_s1_r;
  reg  [6:0]  pin_s2_r;
  integer     i;
  wire [8:0]  par_ok;
  wire        user_perr;
  wire        fw_perr;
  wire        lock;
  wire        pending;
  wire        fault;
  wire        tmo_hit;

  assign mem_req = go_r;

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_par
      assign par_ok[gi] = ^cell_r[gi];
    end
  endgenerate

  assign user_perr = ~&par_ok[2:0];
  assign fw_perr   = ~&par_ok[8:4];
  assign lock      = cell_r[`CELL_CTRL][`LOCK_BIT];
  assign pending   = ~(state_r == ST_IDLE || state_r == ST_INIT);
  assign fault     = fw_perr | safe_perr_r | pin_s2_r[6];
  // Whole-call limit or per-cell limit, whichever runs out first
  assign tmo_hit   = (tmo_r >= lim_r) | (step_r >= CELL_CYC[21:0]);

  // Pins are asynchronous to clk
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
    end else begin
      pin_s1_r <= {peripheral_fault_input, parameter_pin_one,
                   parameter_pin_zero, data_port_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_INIT;
      go_r        <= 1'b1;
      tmo_r       <= 22'h000000;
      step_r      <= 22'h000000;
      lim_r       <= INIT_CYC[21:0];
      idx_r       <= 4'h0;
      wr_addr_r   <= 4'h0;
      wr_data_r   <= 5'h00;
      mem_we      <= 1'b0;
      mem_addr    <= 4'h0;
      mem_wdata   <= 6'h00;
      marker_r    <= 1'b0;
      user_bad_r  <= 1'b0;
      safe_perr_r <= 1'b0;
      init_done   <= 1'b0;
      // Odd-parity blanks keep the fault bit defined before read-out
      for (i = 0; i < 9; i = i + 1)
        cell_r[i] <= 6'h20;
    end else begin
      go_r   <= 1'b0;
      tmo_r  <= tmo_r + 22'h000001;
      step_r <= step_r + 22'h000001;
      case (state_r)
        ST_INIT: begin
          if (mem_done) begin
            go_r   <= 1'b1;
            step_r <= 22'h000000;
            if (safety_mode && idx_r != `MARKER_ADDR && !(^safe_rdata))
              safe_perr_r <= 1'b1;
            if (idx_r == `MARKER_ADDR) begin
              go_r       <= 1'b0;
              marker_r   <= mem_rdata[0];
              user_bad_r <= mem_rdata[0] | user_perr;
              init_done  <= 1'b1;
              state_r    <= ST_IDLE;
            end else begin
              cell_r[idx_r] <= mem_rdata;
              idx_r    <= (idx_r == `CELL_LAST) ? `MARKER_ADDR
                                                : idx_r + 4'h1;
              mem_addr <= (idx_r == `CELL_LAST) ? `MARKER_ADDR
                                                : idx_r + 4'h1;
            end
          end else if (tmo_r >= lim_r) begin
            // A memory that never answers leaves safe defaults
            user_bad_r  <= 1'b1;
            safe_perr_r <= 1'b1;
            init_done   <= 1'b1;
            state_r     <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          mem_we <= 1'b0;
          if (addr_assign_call) begin
            wr_addr_r <= `CELL_SLAVE_ADDR;
            wr_data_r <= new_address;
            lim_r     <= lock ? ADDR_LOCK_CYC[21:0]
                              : ADDR_OPEN_CYC[21:0];
          end else begin
            wr_addr_r <= lock ? `CELL_ID1_USER : `CELL_ID1_MFR;
            wr_data_r <= {1'b0, new_ext_id_one};
            lim_r     <= lock ? ID1_USER_CYC[21:0]
                              : ID1_MFR_CYC[21:0];
          end
          if (addr_assign_call || (write_ext_id_one_call &&
              !(lock && cell_r[`CELL_ID2][`ID1_INHIBIT_BIT]))) begin
            state_r   <= ST_MSET_W;
            go_r      <= 1'b1;
            tmo_r     <= 22'h000000;
            step_r    <= 22'h000000;
            mem_we    <= 1'b1;
            mem_addr  <= `MARKER_ADDR;
            mem_wdata <= enc(`MARKER_ON);
            marker_r  <= 1'b1;
          end
        end
        ST_MSET_W: begin
          if (mem_done) begin
            state_r <= ST_MSET_R;
            go_r    <= 1'b1;
            step_r  <= 22'h000000;
            mem_we  <= 1'b0;
          end
        end
        ST_MSET_R: begin
          if (mem_done) begin
            step_r <= 22'h000000;
            if (mem_rdata == enc(`MARKER_ON)) begin
              state_r   <= ST_DATA_W;
              go_r      <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= wr_addr_r;
              mem_wdata <= enc(wr_data_r);
            end else begin
              // Marker did not take; S3 stays up so the master retries
              state_r <= ST_IDLE;
            end
          end
        end
        ST_DATA_W: begin
          if (mem_done) begin
            state_r <= ST_DATA_R;
            go_r    <= 1'b1;
            step_r  <= 22'h000000;
            mem_we  <= 1'b0;
          end
        end
        ST_DATA_R: begin
          if (mem_done) begin
            step_r <= 22'h000000;
            if (mem_rdata == enc(wr_data_r)) begin
              cell_r[wr_addr_r] <= mem_rdata;
              // Other user cells may still carry a parity fault
              user_bad_r <= ~&(par_ok[2:0] |
                               (3'h1 << wr_addr_r[1:0]));
              state_r    <= ST_MCLR_W;
              go_r       <= 1'b1;
              mem_we     <= 1'b1;
              mem_addr   <= `MARKER_ADDR;
              mem_wdata  <= enc(`MARKER_OFF);
            end else begin
              if (!(^mem_rdata))
                user_bad_r <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_MCLR_W: begin
          if (mem_done) begin
            state_r <= ST_MCLR_R;
            go_r    <= 1'b1;
            step_r  <= 22'h000000;
            mem_we  <= 1'b0;
          end
        end
        ST_MCLR_R: begin
          if (mem_done) begin
            if (mem_rdata == enc(`MARKER_OFF))
              marker_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
      // Abandoned writes keep the marker set so the master sees a failure
      if (pending && tmo_hit && !mem_done) begin
        state_r <= ST_IDLE;
        go_r    <= 1'b0;
        mem_we  <= 1'b0;
      end
    end
  end

  // Decoded configuration and status, all registered
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_resp          <= 4'h0;
      status_valid         <= 1'b0;
      broadcast_reset_exec <= 1'b0;
      slave_address        <= `ADDR_CORRUPT;
      profile_code         <= `CODE_CORRUPT;
      extension_id_one     <= 4'h0;
      extension_id_two     <= 4'h0;
      io_code              <= `CODE_CORRUPT;
      data_port_used       <= 4'h0;
      watchdog_enable      <= 1'b0;
      delay_active         <= 1'b0;
    end else begin
      status_valid <= read_status_call;
      // S2 has no source in this block and reads zero
      if (read_status_call)
        status_resp <= {marker_r, 1'b0, fault, pending};
      broadcast_reset_exec <= broadcast_reset_call & init_done &
                              ~cell_r[`CELL_CTRL][`BR_BLOCK_BIT];
      slave_address <= user_bad_r ? `ADDR_CORRUPT
                       : cell_r[`CELL_SLAVE_ADDR][4:0];
      profile_code  <= user_bad_r ? `CODE_CORRUPT
                       : cell_r[`CELL_PROFILE][3:0];
      io_code       <= user_bad_r ? `CODE_CORRUPT
                       : cell_r[`CELL_IO][3:0];
      extension_id_one <= lock ? cell_r[`CELL_ID1_USER][3:0]
                               : cell_r[`CELL_ID1_MFR][3:0];
      extension_id_two <= cell_r[`CELL_ID2][3:0];
      data_port_used   <= pin_s2_r[3:0] ^
                          {4{cell_r[`CELL_CTRL][`INVERT_IN_BIT]}};
      watchdog_enable  <= init_done &
                          ~cell_r[`CELL_CTRL][`WD_INHIBIT_BIT] &
                          (~cell_r[`CELL_CTRL2][`WD_PIN_SEL_BIT] |
                           pin_s2_r[4]);
      delay_active     <= cell_r[`CELL_IO][`DELAY_PIN_SEL_BIT]
                          ? pin_s2_r[5]
                          : cell_r[`CELL_CTRL][`DELAY_MODE_BIT];
    end
  end

endmodule

/* test/nvm_model.sv */
// Behavioural model of the configuration memory macro.
// Assumes the controller clock; bad_rb corrupts user-cell read-backs.
`timescale 1ns/1ps
module nvm_model #(
  parameter integer LAT = 3
) (
  input  wire       clk,
  input  wire       mem_req,
  input  wire       mem_we,
  input  wire [3:0] mem_addr,
  input  wire [5:0] mem_wdata,
  input  wire       bad_rb,
  output reg        mem_done,
  output reg  [5:0] mem_rdata,
  output reg  [5:0] safe_rdata
);
  reg [5:0] mem [0:15];
  reg [3:0] a;
  reg       w;
  integer   cnt = 0;
  initial begin
    mem_done = 1'b0;
    mem_rdata = 6'h2A;
    safe_rdata = 6'h20;
  end
  always @(posedge clk) begin
    mem_done <= 1'b0;
    // Stale read data would hide a missed handshake
    mem_rdata <= ~mem_rdata;
    // Flipping all six bits keeps the safety word at odd parity
    safe_rdata <= ~safe_rdata;
    if (mem_req) begin
      a <= mem_addr;
      w <= mem_we;
      cnt <= LAT;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      mem_done <= 1'b1;
      if (w)
        mem[a] <= mem_wdata;
      else
        mem_rdata <= (bad_rb && a != 4'hF) ? mem[a] ^ 6'h01 : mem[a];
    end
  end
endmodule

/* test/nvm_props.sv */
// Port assertions for the configuration memory controller.
// Bound from tb; single clock, async active-low reset.
`timescale 1ns/1ps
module nvm_props #(
  parameter integer INIT_CYC = 200
) (
  input wire       clk,
  input wire       rst_n,
  input wire       read_status_call,
  input wire       broadcast_reset_call,
  input wire       mem_req,
  input wire       mem_we,
  input wire [3:0] mem_addr,
  input wire [5:0] mem_wdata,
  input wire       init_done,
  input wire [3:0] status_resp,
  input wire       status_valid,
  input wire       broadcast_reset_exec
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int cyc_r;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      cyc_r <= 0;
    else if (!init_done)
      cyc_r <= cyc_r + 1;
  req_pulse_a: assert property (
    mem_req |=> !mem_req) else $error("mem_req not a pulse");
  wr_parity_a: assert property (
    mem_req && mem_we |-> ^mem_wdata) else $error("even parity written");
  wr_target_a: assert property (
    mem_req && mem_we |-> mem_addr inside {4'h0, 4'h1, 4'h2, 4'hF})
    else $error("write outside user area");
  data_order_a: assert property (
    mem_req && mem_we && mem_addr != 4'hF |->
    $past(mem_addr) == 4'hF && !$past(mem_we)) else $error("data before mark");
  mark_clear_a: assert property (
    mem_req && mem_we && mem_addr == 4'hF && mem_wdata == 6'h20 |->
    !$past(mem_we) && $past(mem_addr) < 4'h3) else $error("early clear");
  stat_answer_a: assert property (
    read_status_call && init_done |=> status_valid) else $error("no status");
  stat_bit2_a: assert property (
    status_valid |-> !status_resp[2]) else $error("status bit 2 set");
  br_cause_a: assert property (
    broadcast_reset_exec |-> $past(broadcast_reset_call) && $past(init_done))
    else $error("reset without call");
  init_time_a: assert property (
    cyc_r <= INIT_CYC) else $error("init read-out too slow");
  cover property (mem_req && mem_we && mem_addr == 4'hF);
  cover property (status_valid && status_resp[3]);
  cover property (broadcast_reset_exec);
endmodule

/* test/tb.sv */
// Self-checking bench for the configuration memory controller.
// Drives calls at falling edges; memory answered by nvm_model.
`timescale 1ns/1ps
`include "config_nvm_map.vh"
module tb;
  logic clk, rst_n, addr_assign_call, write_ext_id_one_call;
  logic read_status_call, broadcast_reset_call, safety_mode;
  logic peripheral_fault_input, parameter_pin_zero, parameter_pin_one;
  logic [4:0] new_address;
  logic [3:0] new_ext_id_one, data_port_in;
  logic mem_req, mem_we, mem_done, init_done, status_valid, bad_rb;
  logic broadcast_reset_exec, watchdog_enable, delay_active;
  logic [3:0] mem_addr, status_resp, profile_code, extension_id_one;
  logic [3:0] extension_id_two, io_code, data_port_used;
  logic [5:0] mem_wdata, mem_rdata, safe_rdata;
  logic [4:0] slave_address;
  logic [7:0] expq[$];
  logic [7:0] stat_e;
  logic [31:0] rs = 32'h551F;
  int fails = 0, check_count = 0, cyc_n = 0;

  config_nvm_write_check #(.INIT_CYC(200), .ADDR_LOCK_CYC(400),
    .ADDR_OPEN_CYC(300), .ID1_USER_CYC(400), .ID1_MFR_CYC(350),
    .CELL_CYC(100)) u_dut (.clk, .rst_n, .addr_assign_call, .new_address,
    .write_ext_id_one_call, .new_ext_id_one, .read_status_call,
    .broadcast_reset_call, .safety_mode, .peripheral_fault_input,
    .parameter_pin_zero, .parameter_pin_one, .data_port_in, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_done, .mem_rdata, .safe_rdata,
    .init_done, .status_resp, .status_valid, .broadcast_reset_exec,
    .slave_address, .profile_code, .extension_id_one, .extension_id_two,
    .io_code, .data_port_used, .watchdog_enable, .delay_active);
  nvm_model u_mem (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .bad_rb,
    .mem_done, .mem_rdata, .safe_rdata);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [5:0] enc(input logic [4:0] d);
    return {~^d, d};
  endfunction
  task automatic stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd_stat(input logic [3:0] e);
    expq.push_back({4'h0, e});
    read_status_call = 1'b1;
    tick(1);
    read_status_call = 1'b0;
    tick(1);
  endtask
  task automatic wr(input logic id, input logic [4:0] d);
    write_ext_id_one_call = id;
    addr_assign_call = !id;
    new_ext_id_one = d[3:0];
    new_address = d;
    tick(1);
    write_ext_id_one_call = 1'b0;
    addr_assign_call = 1'b0;
  endtask
  task automatic br(input logic e);
    broadcast_reset_call = 1'b1;
    tick(1);
    broadcast_reset_call = 1'b0;
    chk("brst", {7'h0, e}, {7'h0, broadcast_reset_exec});
  endtask
  task automatic load(input logic [4:0] c7, input logic [5:0] fx,
                      input logic [4:0] mk);
    for (int i = 0; i < 16; i++) u_mem.mem[i] = enc(5'h00);
    u_mem.mem[0] = enc(5'h0A);
    u_mem.mem[4] = enc(5'h03);
    u_mem.mem[5] = enc(5'h07) ^ fx;
    u_mem.mem[6] = enc(5'h15);
    u_mem.mem[7] = enc(c7);
    u_mem.mem[8] = enc(5'h01);
    u_mem.mem[15] = enc(mk);
  endtask
  task automatic boot();
    rst_n = 1'b0;
    tick(12);
    rst_n = 1'b1;
    for (int i = 0; i < 300 && init_done !== 1'b1; i++) tick(1);
    chk("init", 8'h01, {7'h0, init_done});
    // Decoded outputs settle one edge after init_done
    tick(2);
  endtask

  always @(negedge clk)
    if (status_valid === 1'b1) begin
      stat_e = expq.size() ? expq.pop_front() : 8'hEE;
      chk("status", stat_e, {4'h0, status_resp});
    end
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    {addr_assign_call, write_ext_id_one_call, read_status_call} = 3'h0;
    {broadcast_reset_call, peripheral_fault_input, bad_rb} = 3'h0;
    {parameter_pin_zero, parameter_pin_one, safety_mode} = 3'h1;
    new_address = 5'h00;
    new_ext_id_one = 4'h0;
    data_port_in = 4'h0;
    load(5'h00, 6'h00, 5'h00);
    boot();
    chk("addr", 8'h0A, {3'h0, slave_address});
    chk("prof", 8'h03, {4'h0, profile_code});
    chk("io", 8'h05, {4'h0, io_code});
    chk("id2", 8'h07, {4'h0, extension_id_two});
    rd_stat(4'h0);
    for (int p = 0; p < 2; p++) begin
      parameter_pin_zero = p[0];
      parameter_pin_one = p[0];
      rs = xs(rs);
      data_port_in = rs[3:0];
      tick(5);
      chk("wdog", {7'h0, p[0]}, {7'h0, watchdog_enable});
      chk("dly", {7'h0, p[0]}, {7'h0, delay_active});
      chk("port", {4'h0, rs[3:0]}, {4'h0, data_port_used});
    end
    rs = xs(rs);
    wr(1'b0, rs[4:0]);
    tick(3);
    rd_stat(4'h9);
    wr(1'b0, ~rs[4:0]);
    tick(80);
    rd_stat(4'h0);
    chk("addr", {3'h0, rs[4:0]}, {3'h0, slave_address});
    wr(1'b1, 5'h06);
    tick(80);
    chk("id1", 8'h06, {4'h0, extension_id_one});
    bad_rb = 1'b1;
    wr(1'b0, 5'h13);
    tick(80);
    bad_rb = 1'b0;
    rd_stat(4'h8);
    chk("addr", 8'h00, {3'h0, slave_address});
    wr(1'b0, 5'h13);
    tick(80);
    rd_stat(4'h0);
    chk("addr", 8'h13, {3'h0, slave_address});
    br(1'b1);
    peripheral_fault_input = 1'b1;
    tick(4);
    rd_stat(4'h2);
    peripheral_fault_input = 1'b0;
    rs = xs(rs);
    safety_mode = rs[0];
    load(5'h17, 6'h20, 5'h01);
    boot();
    chk("addr", 8'h00, {3'h0, slave_address});
    chk("prof", 8'h0F, {4'h0, profile_code});
    chk("io", 8'h0F, {4'h0, io_code});
    rd_stat(4'hA);
    br(1'b0);
    tick(5);
    chk("wdog", 8'h00, {7'h0, watchdog_enable});
    chk("port", {4'h0, ~data_port_in}, {4'h0, data_port_used});
    wr(1'b1, 5'h05);
    tick(80);
    rd_stat(4'h2);
    chk("id1", 8'h05, {4'h0, extension_id_one});
    tick(2);
    stop_test();
  end
endmodule

bind config_nvm_write_check nvm_props #(.INIT_CYC(INIT_CYC)) u_props (
  .clk, .rst_n, .read_status_call, .broadcast_reset_call, .mem_req, .mem_we,
  .mem_addr, .mem_wdata, .init_done, .status_resp, .status_valid,
  .broadcast_reset_exec);
